// ---- verilog/clkgen_pkg.sv ----
`default_nettype none
package clkgen_pkg;
    localparam int NUM_CLK = 6;
    localparam int MAX_DIV = 64;
    localparam int CLK_CORE = 0;
    localparam int CLK_FLASH = 5;
    // Divider code field positions in the divider control register, in the
    // order core, A, B, timer reference, conversion, flash.
    localparam int DIV_LSB [NUM_CLK] = '{24, 12, 8, 4, 0, 28};
    localparam logic [3:0] DIV_CODE_MAX = 4'h6;
    typedef enum logic [1:0] {
        SRC_MAIN = 2'h0,
        SRC_FAST = 2'h1,
        SRC_SLOW = 2'h2,
        SRC_PLL = 2'h3
    } src_t;
    typedef struct packed {
        logic [1:0] src;
        logic [6:0] div;
    } clk_cfg_t;
    localparam logic [7:0] ADDR_DIV = 8'h00;
    localparam logic [7:0] ADDR_SRC = 8'h04;
    localparam logic [7:0] ADDR_PLL = 8'h08;
    localparam logic [7:0] ADDR_FAST = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;
    localparam logic [31:0] DIV_RESET = 32'h00000000;
    localparam logic [11:0] SRC_RESET = 12'hAAA;
    localparam int PLL_REFSEL_BIT = 16;
    localparam int PLL_MULT_LSB = 8;
    localparam int PLL_PREDIV_LSB = 0;
    localparam logic [4:0] PLL_MULT_MIN = 5'h0A;
    localparam logic [4:0] PLL_MULT_MAX = 5'h1E;
    localparam logic [4:0] PLL_MULT_RESET = 5'h0A;
    localparam logic [1:0] PREDIV_CODE_MAX = 2'h2;
    localparam int FAST_FREQ_LSB = 4;
    localparam int FAST_PWR_BIT = 8;
    localparam logic [1:0] FAST_FREQ_MAX = 2'h2;
    localparam int STAT_STOP_BIT = 0;
    localparam int STAT_LIVE_BIT = 1;
    localparam int STAT_FORCE_BIT = 2;
    localparam int CLK_PERIOD_NS = 25;
    localparam int OSC_STOP_NS = 1000;
    localparam int OSC_STOP_CYCLES = OSC_STOP_NS / CLK_PERIOD_NS;
    localparam logic [6:0] QUIET_LIMIT = 7'h7F;
endpackage
`default_nettype wire

// ---- verilog/clk_div_select.sv ----
`timescale 1ns/1ps
`default_nettype none
module clk_div_select #(
    parameter int MAX_DIV = clkgen_pkg::MAX_DIV
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] srcLevels,
    input wire clkgen_pkg::clk_cfg_t cfgReq,
    input wire logic urgent,
    output logic clkOut,
    output clkgen_pkg::clk_cfg_t cfgNow
);
    if (MAX_DIV < 1 || MAX_DIV > 127)
    begin : g_check
        $error("MAX_DIV must lie in 1 to 127");
    end

    logic [3:0] srcPrev_reg;
    clkgen_pkg::clk_cfg_t cur_reg;
    logic [6:0] cnt_reg;
    logic out_reg;
    logic selRise;
    logic selFall;
    logic wrap;
    logic switchOk;
    logic [6:0] quiet_reg;
    logic dead;

    assign selRise = srcLevels[cur_reg.src] & ~srcPrev_reg[cur_reg.src];
    assign selFall = ~srcLevels[cur_reg.src] & srcPrev_reg[cur_reg.src];
    assign wrap = selRise && (cnt_reg == cur_reg.div - 7'h01);
    // A stopped source never wraps, so an urgent change may also go
    // through while the output stands low.
    assign switchOk = (cfgReq != cur_reg) && (wrap || (urgent && !out_reg));
    assign clkOut = out_reg;
    assign cfgNow = cur_reg;
    // A source that shows no edge for this long counts as dead, so an urgent
    // change may end a high phase that would otherwise never end. A live
    // source slower than this limit would see its high phase cut short.
    assign dead = (quiet_reg == clkgen_pkg::QUIET_LIMIT);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            quiet_reg <= 7'h00;
        else if (switchOk || selRise || selFall)
            quiet_reg <= 7'h00;
        else if (!dead)
            quiet_reg <= quiet_reg + 7'h01;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            srcPrev_reg <= 4'h0;
        else
            srcPrev_reg <= srcLevels;
    end

    // The new setting starts low and goes high at the first rise of its source, so no pulse is cut short.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cur_reg <= '{src: 2'h2, div: 7'h01};
            cnt_reg <= 7'h00;
            out_reg <= 1'b0;
        end
        else if (switchOk) // R17
        begin
            cur_reg <= cfgReq;
            cnt_reg <= cfgReq.div - 7'h01;
            out_reg <= 1'b0;
        end
        else if (selRise)
        begin
            cnt_reg <= wrap ? 7'h00 : cnt_reg + 7'h01;
            if (wrap)
                out_reg <= 1'b1;
            else if (cnt_reg + 7'h01 == (cur_reg.div >> 1))
                out_reg <= 1'b0;
        end
        else if (selFall && cur_reg.div == 7'h01)
            out_reg <= 1'b0;
        else if (urgent && dead) // R8
            out_reg <= 1'b0;
    end

    property p_switch_low;
        @(posedge clk) disable iff (sys_rst)
        $changed(cur_reg) |-> !clkOut && $past(wrap || !out_reg);
    endproperty
    a_switch_low: assert property (p_switch_low) // R17
        else $error("Clock selection changed during a high phase");
endmodule
`default_nettype wire

// ---- verilog/clock_generation_divider_select.sv ----
// What this block does
// (R1) Core divider codes 0-6 divide by 2^code.
// (R2) Each clock picks source and divider individually.
// (R3) PLL reference from main or fast oscillator.
// (R4) PLL reference pre-divided by 1, 2 or 3.
// (R5) PLL multiplier selectable from 10 to 30.
// (R6) Software keeps PLL output 120 to 240 MHz.
// (R7) Fast oscillator 16/18/20 MHz, power switchable.
// (R8) Main oscillator stop forces slow source, timers Hi-Z.
// (R9) Oscillator stop emits an event-link output.
// (R10) Event-link input forces the slow oscillator.
// (R11) Stop interrupt enable bit and readable stop status.
// (R12) Software keeps core and peripheral clock limits.
// (R13) Software keeps flash clock within its limits.
// (R14) Software keeps conversion clock 8 to 60 MHz.
// (R15) Software keeps CAN FD clocks within limits.
// (R16) Timer reference clock goes to the timers.
// (R17) Selections change only at a safe edge.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module clock_generation_divider_select #(
    parameter int STOP_CYCLES = clkgen_pkg::OSC_STOP_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mainOscLevel,
    input wire logic fastOscLevel,
    input wire logic slowOscLevel,
    input wire logic pllOutLevel,
    input wire logic slowSwitchEventIn,
    output logic oscStopEventOut,
    output logic irq,
    output logic coreClock,
    output logic peripheralClockA,
    output logic peripheralClockB,
    output logic timerReferenceClock,
    output logic conversionClock,
    output logic flashInterfaceClock,
    output logic pllRefClock,
    output logic pllRefFromFast,
    output logic [4:0] pllMultiplier,
    output logic [1:0] fastOscFreqSel,
    output logic fastOscPowerOn,
    output logic motorTimerHiZ,
    output logic pwmTimerHiZ
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    if (STOP_CYCLES < 2 || STOP_CYCLES > 65535)
    begin : g_check
        $error("STOP_CYCLES must lie in 2 to 65535");
    end

    localparam logic [15:0] STOP_LIMIT = 16'(STOP_CYCLES);

    logic [31:0] div_reg;
    logic [11:0] src_reg;
    logic refSel_reg;
    logic [1:0] preDiv_reg;
    logic [4:0] mult_reg;
    logic [1:0] fastFreq_reg;
    logic fastPwr_reg;
    logic stat_reg;
    logic mask_reg;
    logic forceSlow_reg;
    logic [15:0] idle_reg;
    logic stopped_reg;
    logic mainPrev_reg;
    logic event_reg;
    logic [31:0] rdata_reg;
    logic wrEn;
    logic rdEn;
    logic mapped;
    logic stopDetect;
    logic [3:0] srcLevels;
    logic [clkgen_pkg::NUM_CLK-1:0] clkOuts;
    clkgen_pkg::clk_cfg_t cfgReq [clkgen_pkg::NUM_CLK];
    clkgen_pkg::clk_cfg_t preCfg;

    // Zero-wait slave: the setup cycle already prepares read data.
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && !penable && !pwrite;
    assign mapped = (paddr == clkgen_pkg::ADDR_DIV)
        || (paddr == clkgen_pkg::ADDR_SRC)
        || (paddr == clkgen_pkg::ADDR_PLL)
        || (paddr == clkgen_pkg::ADDR_FAST)
        || (paddr == clkgen_pkg::ADDR_STAT)
        || (paddr == clkgen_pkg::ADDR_MASK);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = rdata_reg;

    // An illegal divider code leaves its field as it was.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            div_reg <= clkgen_pkg::DIV_RESET;
        else if (wrEn && paddr == clkgen_pkg::ADDR_DIV)
        begin
            for (int i = 0; i < clkgen_pkg::NUM_CLK; i++)
            begin
                if (pwdata[clkgen_pkg::DIV_LSB[i] +: 4]
                    <= clkgen_pkg::DIV_CODE_MAX) // R1
                    div_reg[clkgen_pkg::DIV_LSB[i] +: 4] <=
                        pwdata[clkgen_pkg::DIV_LSB[i] +: 4];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            src_reg <= clkgen_pkg::SRC_RESET;
        else if (wrEn && paddr == clkgen_pkg::ADDR_SRC)
            src_reg <= pwdata[11:0]; // R2
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            refSel_reg <= 1'b0;
            preDiv_reg <= 2'h0;
            mult_reg <= clkgen_pkg::PLL_MULT_RESET;
        end
        else if (wrEn && paddr == clkgen_pkg::ADDR_PLL)
        begin
            refSel_reg <= pwdata[clkgen_pkg::PLL_REFSEL_BIT]; // R3
            if (pwdata[clkgen_pkg::PLL_PREDIV_LSB +: 2]
                <= clkgen_pkg::PREDIV_CODE_MAX)
                preDiv_reg <= pwdata[clkgen_pkg::PLL_PREDIV_LSB +: 2]; // R4
            if (pwdata[clkgen_pkg::PLL_MULT_LSB +: 5]
                >= clkgen_pkg::PLL_MULT_MIN
                && pwdata[clkgen_pkg::PLL_MULT_LSB +: 5]
                <= clkgen_pkg::PLL_MULT_MAX)
                mult_reg <= pwdata[clkgen_pkg::PLL_MULT_LSB +: 5]; // R5
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fastFreq_reg <= 2'h0;
            fastPwr_reg <= 1'b0;
        end
        else if (wrEn && paddr == clkgen_pkg::ADDR_FAST)
        begin
            if (pwdata[clkgen_pkg::FAST_FREQ_LSB +: 2]
                <= clkgen_pkg::FAST_FREQ_MAX)
                fastFreq_reg <= pwdata[clkgen_pkg::FAST_FREQ_LSB +: 2]; // R7
            fastPwr_reg <= pwdata[clkgen_pkg::FAST_PWR_BIT]; // R7
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            mask_reg <= 1'b0;
        else if (wrEn && paddr == clkgen_pkg::ADDR_MASK)
            mask_reg <= pwdata[clkgen_pkg::STAT_STOP_BIT]; // R11
    end

    // Stop detection counts system cycles without any main oscillator edge.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mainPrev_reg <= 1'b0;
            idle_reg <= 16'h0000;
            stopped_reg <= 1'b0;
        end
        else
        begin
            mainPrev_reg <= mainOscLevel;
            if (mainOscLevel != mainPrev_reg)
            begin
                idle_reg <= 16'h0000;
                stopped_reg <= 1'b0;
            end
            else if (idle_reg < STOP_LIMIT)
                idle_reg <= idle_reg + 16'h0001;
            else
                stopped_reg <= 1'b1;
        end
    end

    assign stopDetect = (idle_reg >= STOP_LIMIT) && !stopped_reg
        && (mainOscLevel == mainPrev_reg);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            event_reg <= 1'b0;
        else
            event_reg <= stopDetect; // R9
    end

    // A detection in the same cycle as a clear keeps the flag set.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            stat_reg <= 1'b0;
        else if (stopDetect)
            stat_reg <= 1'b1; // R11
        else if (wrEn && paddr == clkgen_pkg::ADDR_STAT
            && pwdata[clkgen_pkg::STAT_STOP_BIT])
            stat_reg <= 1'b0;
    end

    // The fallback holds until software rewrites the source selection.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            forceSlow_reg <= 1'b0;
        else if (stopDetect || slowSwitchEventIn) // R8 R10
            forceSlow_reg <= 1'b1;
        else if (wrEn && paddr == clkgen_pkg::ADDR_SRC)
            forceSlow_reg <= 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdata_reg <= 32'h00000000;
        else if (rdEn)
        begin
            if (paddr == clkgen_pkg::ADDR_DIV)
                rdata_reg <= div_reg;
            else if (paddr == clkgen_pkg::ADDR_SRC)
                rdata_reg <= {20'h00000, src_reg};
            else if (paddr == clkgen_pkg::ADDR_PLL)
                rdata_reg <= {15'h0000, refSel_reg, 3'h0, mult_reg,
                    6'h00, preDiv_reg};
            else if (paddr == clkgen_pkg::ADDR_FAST)
                rdata_reg <= {23'h000000, fastPwr_reg, 2'h0,
                    fastFreq_reg, 4'h0};
            else if (paddr == clkgen_pkg::ADDR_STAT)
                rdata_reg <= {29'h00000000, forceSlow_reg, stopped_reg,
                    stat_reg}; // R11
            else if (paddr == clkgen_pkg::ADDR_MASK)
                rdata_reg <= {31'h00000000, mask_reg};
            else
                rdata_reg <= 32'h00000000;
        end
    end

    assign srcLevels = {pllOutLevel, slowOscLevel, fastOscLevel, mainOscLevel};

    always_comb
    begin
        for (int i = 0; i < clkgen_pkg::NUM_CLK; i++)
        begin
            cfgReq[i].src = src_reg[2*i +: 2];
            cfgReq[i].div = 7'h01 << div_reg[clkgen_pkg::DIV_LSB[i] +: 3];
        end
        if (forceSlow_reg)
            cfgReq[clkgen_pkg::CLK_CORE].src = clkgen_pkg::SRC_SLOW; // R8
    end

    genvar g;
    for (g = 0; g < clkgen_pkg::NUM_CLK; g++)
    begin : g_clk
        clk_div_select #(
            .MAX_DIV(clkgen_pkg::MAX_DIV)
        ) u_div (
            .clk(clk),
            .sys_rst(sys_rst),
            .srcLevels(srcLevels),
            .cfgReq(cfgReq[g]), // R2
            .urgent(g == clkgen_pkg::CLK_CORE && forceSlow_reg),
            .clkOut(clkOuts[g]),
            .cfgNow()
        );
    end

    assign preCfg.src = refSel_reg ? clkgen_pkg::SRC_FAST
        : clkgen_pkg::SRC_MAIN; // R3
    assign preCfg.div = 7'h01 + {5'h00, preDiv_reg}; // R4

    clk_div_select #(
        .MAX_DIV(clkgen_pkg::MAX_DIV)
    ) u_pre (
        .clk(clk),
        .sys_rst(sys_rst),
        .srcLevels(srcLevels),
        .cfgReq(preCfg),
        .urgent(1'b0),
        .clkOut(pllRefClock),
        .cfgNow()
    );

    assign coreClock = clkOuts[0];
    assign peripheralClockA = clkOuts[1];
    assign peripheralClockB = clkOuts[2];
    assign timerReferenceClock = clkOuts[3]; // R16
    assign conversionClock = clkOuts[4];
    assign flashInterfaceClock = clkOuts[clkgen_pkg::CLK_FLASH];
    assign pllRefFromFast = refSel_reg;
    assign pllMultiplier = mult_reg; // R5
    assign fastOscFreqSel = fastFreq_reg;
    assign fastOscPowerOn = fastPwr_reg;
    assign oscStopEventOut = event_reg;
    assign irq = stat_reg && mask_reg; // R11
    // Timer pins stay released until software clears the stop status.
    assign motorTimerHiZ = stat_reg; // R8
    assign pwmTimerHiZ = stat_reg; // R8

    property p_div_legal;
        div_reg[27:24] <= clkgen_pkg::DIV_CODE_MAX;
    endproperty
    a_div_legal: assert property (p_div_legal) // R1
        else $error("Core divider holds an illegal code");
    property p_src_write;
        wrEn && paddr == clkgen_pkg::ADDR_SRC
            |=> src_reg == $past(pwdata[11:0]) && !forceSlow_reg
                || $past(stopDetect || slowSwitchEventIn);
    endproperty
    a_src_write: assert property (p_src_write) // R2
        else $error("Source selection write not taken");
    property p_prediv;
        preDiv_reg <= clkgen_pkg::PREDIV_CODE_MAX;
    endproperty
    a_prediv: assert property (p_prediv) // R4
        else $error("PLL pre-divider code illegal");
    property p_mult;
        pllMultiplier >= clkgen_pkg::PLL_MULT_MIN
            && pllMultiplier <= clkgen_pkg::PLL_MULT_MAX;
    endproperty
    a_mult: assert property (p_mult) // R5
        else $error("PLL multiplier out of range");
    property p_stop_fallback;
        stopDetect |=> forceSlow_reg && motorTimerHiZ && pwmTimerHiZ
            && cfgReq[clkgen_pkg::CLK_CORE].src == clkgen_pkg::SRC_SLOW;
    endproperty
    a_stop_fallback: assert property (p_stop_fallback) // R8
        else $error("Oscillator stop did not force fallback");
    property p_stop_event;
        stopDetect |=> oscStopEventOut ##1 !oscStopEventOut;
    endproperty
    a_stop_event: assert property (p_stop_event) // R9
        else $error("Stop event not a single pulse");
    property p_event_in;
        slowSwitchEventIn |=> forceSlow_reg;
    endproperty
    a_event_in: assert property (p_event_in) // R10
        else $error("Event input did not force slow source");
    property p_irq;
        stopDetect && mask_reg |=> irq;
    endproperty
    a_irq: assert property (p_irq) // R11
        else $error("Enabled stop did not raise interrupt");
    c_stop: cover property (oscStopEventOut);
    c_event_in: cover property (slowSwitchEventIn ##1 forceSlow_reg);
    c_irq: cover property (irq);
    c_clear: cover property (stat_reg ##1 !stat_reg);
endmodule
`default_nettype wire

// ---- testbench/osc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module osc_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic mainRun,
    output logic mainOscLevel,
    output logic fastOscLevel,
    output logic slowOscLevel,
    output logic pllOutLevel
);
    logic [5:0] cnt;
    // Sixty steps are a common multiple of every period, so no source
    // shows a short phase when the step counter wraps.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt <= 6'h00;
            mainOscLevel <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == 6'h3B) ? 6'h00 : cnt + 6'h01;
            // A stopped resonator holds its level; only missing edges
            // reveal that it has died.
            if (mainRun)
                mainOscLevel <= cnt[1];
        end
    end
    assign fastOscLevel = (cnt % 6) >= 3;
    assign slowOscLevel = (cnt % 10) >= 5;
    assign pllOutLevel = cnt[0];
endmodule
`default_nettype wire

// ---- testbench/clock_generation_divider_select_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module clock_generation_divider_select_test;
    localparam logic [7:0] A_DIV = clkgen_pkg::ADDR_DIV;
    localparam logic [7:0] A_SRC = clkgen_pkg::ADDR_SRC;
    localparam logic [7:0] A_PLL = clkgen_pkg::ADDR_PLL;
    localparam logic [7:0] A_FAST = clkgen_pkg::ADDR_FAST;
    localparam logic [7:0] A_STAT = clkgen_pkg::ADDR_STAT;
    localparam logic [7:0] A_MASK = clkgen_pkg::ADDR_MASK;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic slowSwitchEventIn = 1'b0;
    logic mainRun = 1'b1;
    logic mainOscLevel, fastOscLevel, slowOscLevel, pllOutLevel;
    logic [31:0] prdata;
    logic pready, pslverr, oscStopEventOut, irq, pllRefClock;
    logic coreClock, peripheralClockA, peripheralClockB, timerReferenceClock;
    logic conversionClock, flashInterfaceClock, fastOscPowerOn;
    logic motorTimerHiZ, pwmTimerHiZ, pllRefFromFast;
    logic [4:0] pllMultiplier;
    logic [1:0] fastOscFreqSel;
    logic [6:0] clkVec;
    logic [31:0] expq[$];
    int fails = 0;
    int checks = 0;
    int srcPer[4] = '{4, 6, 10, 2};

    always #12.5 clk = ~clk;
    assign clkVec = {pllRefClock, flashInterfaceClock, conversionClock,
        timerReferenceClock, peripheralClockB, peripheralClockA, coreClock};

    osc_model osc (.clk, .sys_rst, .mainRun, .mainOscLevel, .fastOscLevel,
        .slowOscLevel, .pllOutLevel);
    clock_generation_divider_select #(.STOP_CYCLES(8)) dut (.clk, .sys_rst,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .mainOscLevel, .fastOscLevel, .slowOscLevel, .pllOutLevel,
        .slowSwitchEventIn, .oscStopEventOut, .irq, .coreClock,
        .peripheralClockA, .peripheralClockB, .timerReferenceClock,
        .conversionClock, .flashInterfaceClock, .pllRefClock, .pllRefFromFast,
        .pllMultiplier, .fastOscFreqSel, .fastOscPowerOn, .motorTimerHiZ,
        .pwmTimerHiZ);

    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // A read notes its expected word; the watcher below compares it.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w)
            expq.push_back(d);
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
        if (n >= 50)
        begin
            fails++;
            give_verdict();
        end
    endtask

    always @(posedge clk)
    begin
        if (psel && penable && pready)
        begin
            check("pslverr", 32'(pslverr), 32'(paddr > A_MASK));
            if (!pwrite)
                check("prdata", prdata, expq.size() ? expq.pop_front() : 'x);
        end
    end

    task automatic rise(input int i, output int n);
        logic p;
        n = 0;
        p = 1'b1;
        while (!(p === 1'b0 && clkVec[i] === 1'b1) && n < 3000)
        begin
            p = clkVec[i];
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 3000)
        begin
            fails++;
            give_verdict();
        end
    endtask

    // The first rise may still belong to the previous setting.
    task automatic per(input int i, input int exp);
        int n;
        rise(i, n);
        rise(i, n);
        rise(i, n);
        check("clock period", 32'(n), 32'(exp));
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        fails++;
        give_verdict();
    end

    initial
    begin
        int s[6];
        int c[6];
        int n;
        logic [31:0] sv;
        logic [31:0] dv;
        logic [31:0] pv[6];
        logic [31:0] pe[6];
        int pp[6];
        pv = '{32'h00000A00, 32'h00001E01, 32'h00011402, 32'h00000F02,
            32'h00001F03, 32'h00000902};
        pe = '{32'h00000A00, 32'h00001E01, 32'h00011402, 32'h00000F02,
            32'h00000F02, 32'h00000F02};
        pp = '{4, 8, 18, 12, 12, 12};
        void'($urandom(32'hDE7A7AF2));
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        apb(0, A_DIV, clkgen_pkg::DIV_RESET);
        apb(0, A_SRC, 32'h00000AAA);
        apb(0, A_PLL, 32'h00000A00);
        apb(0, A_FAST, 32'h00000000);
        apb(0, A_STAT, 32'h00000000);
        apb(0, A_MASK, 32'h00000000);
        apb(0, 8'h20, 32'h00000000);
        for (int k = 0; k < 7; k++)
        begin
            apb(1, A_DIV, 32'(k) << 24);
            apb(0, A_DIV, 32'(k) << 24);
            per(0, 10 << k);
        end
        apb(1, A_DIV, 32'h07000000);
        apb(0, A_DIV, 32'h06000000);
        for (int f = 0; f < 4; f++)
        begin
            apb(1, A_FAST, (32'(f % 2) << 8) | (32'(f) << 4));
            check("freq", 32'(fastOscFreqSel), 32'(f < 3 ? f : 2));
            check("power", 32'(fastOscPowerOn), 32'(f % 2));
        end
        sv = 32'h0;
        dv = 32'h0;
        for (int i = 0; i < 6; i++)
        begin
            s[i] = $urandom % 4;
            c[i] = $urandom % 3;
            sv |= 32'(s[i]) << (2 * i);
            dv |= 32'(c[i]) << clkgen_pkg::DIV_LSB[i];
        end
        apb(1, A_SRC, sv);
        apb(1, A_DIV, dv);
        apb(0, A_SRC, sv);
        apb(0, A_DIV, dv);
        for (int i = 0; i < 6; i++)
            per(i, srcPer[s[i]] << c[i]);
        for (int i = 0; i < 6; i++)
        begin
            apb(1, A_PLL, pv[i]);
            apb(0, A_PLL, pe[i]);
            check("mult", 32'(pllMultiplier), 32'(pe[i][12:8]));
            check("ref", 32'(pllRefFromFast), 32'(pe[i][16]));
            per(6, pp[i]);
        end
        apb(1, A_DIV, 32'h00000000);
        apb(1, A_SRC, 32'h00000AA8);
        apb(1, A_MASK, 32'h00000001);
        per(0, 4);
        mainRun <= 1'b0;
        n = 0;
        while (oscStopEventOut !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("stop event", 32'(oscStopEventOut), 32'h1);
        @(posedge clk);
        #1;
        check("stop event", 32'(oscStopEventOut), 32'h0);
        check("irq", 32'(irq), 32'h1);
        check("hiz", 32'({motorTimerHiZ, pwmTimerHiZ}), 32'h3);
        apb(0, A_STAT, 32'h00000007);
        per(0, 10);
        apb(1, A_MASK, 32'h00000000);
        @(posedge clk);
        #1;
        check("irq", 32'(irq), 32'h0);
        mainRun <= 1'b1;
        repeat (20) @(posedge clk);
        apb(1, A_STAT, 32'h00000001);
        apb(0, A_STAT, 32'h00000004);
        check("hiz", 32'({motorTimerHiZ, pwmTimerHiZ}), 32'h0);
        apb(1, A_SRC, 32'h00000AA8);
        apb(0, A_STAT, 32'h00000000);
        per(0, 4);
        @(posedge clk);
        slowSwitchEventIn <= 1'b1;
        @(posedge clk);
        slowSwitchEventIn <= 1'b0;
        apb(0, A_STAT, 32'h00000004);
        per(0, 10);
        apb(1, A_SRC, 32'h00000AA8);
        per(0, 4);
        give_verdict();
    end
endmodule
`default_nettype wire
